// ---- logic/iru_pkg.sv ----
// Function
// RULE_01: a non-zero clock select drives the chosen clock out on the av clock pin
// RULE_02: select 00 makes the pin an input; 01/10/11 give 24.576/12.288/6.144 MHz
// RULE_03: with send_at_once set, a packet with crc error is released at once
// RULE_04: with send_at_once clear, every packet waits for its time stamp; the code releases it without waiting when stamp checking is off
// RULE_05: stamp checking on after reset; when off, stamp quadlet precedes each packet
// RULE_06: the application must accept the extra stamp quadlet when checking is off
// RULE_07: with drop_bad_packets set, packets with crc error are discarded from memory
// RULE_08: read-only packet_ready_flag shows a stored packet awaits delivery
// RULE_09: rx_enable_bit is sampled only at the start of each new bus packet
// RULE_10: byte_pad_trim removes 0 to 3 bytes from each packet's last data quadlet
// RULE_11: syt_process_enable turns on handling of syt stamps in received packets
// RULE_12: rx_soft_reset resets the receiver on av clock; hold it one av period
// RULE_13: software disables receive and waits for the buffer to drain before reset
// RULE_14: header quadlet one holds the last received bus header while operating
// RULE_15: header quadlet two bits 31..30 hold the end-of-header and form marker
// RULE_16: header quadlet two bits 29..24 hold the received format code
// RULE_17: bits 23..0 hold format-dependent field; low 16 bits are syt when enabled
// RULE_18: each stored packet keeps its crc error status beside it for delivery
package iru_pkg;
  // register offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h040;
  localparam logic [11:0] HQ1_OFFSET = 12'h044;
  localparam logic [11:0] HQ2_OFFSET = 12'h048;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h04c;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h050;
  // reset values and writable bits
  localparam logic [31:0] CTRL_RESET = 32'h00000041;
  localparam logic [31:0] CTRL_WMASK = 32'h300001df;
  localparam logic [31:0] HQ2_RESET = 32'h0000ffff;
  // control field positions
  localparam int CLK_SEL_LSB = 28;
  localparam int SEND_AT_ONCE_BIT = 8;
  localparam int STAMP_OFF_BIT = 7;
  localparam int DROP_BIT = 6;
  localparam int READY_BIT = 5;
  localparam int ENABLE_BIT = 4;
  localparam int PAD_LSB = 2;
  localparam int SYT_EN_BIT = 1;
  localparam int SOFT_RST_BIT = 0;
  // header quadlet two fields
  localparam int FORM_LSB = 30;
  localparam int FMT_LSB = 24;
  localparam logic [15:0] SYT_NONE = 16'hffff;
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_STORED = 0;
  localparam int IRQ_DROPPED = 1;
  localparam int IRQ_LOST = 2;
  localparam int IRQ_DELIVERED = 3;
  // buffer sizes and packet layout
  localparam int MEM_AW = 6;
  localparam logic [MEM_AW:0] MEM_DEPTH = 7'h40;
  localparam int DESC_AW = 3;
  localparam logic [1:0] PAYLOAD_IDX = 2'h3;
  localparam logic [2:0] FULL_BYTES = 3'h4;
  // application clock synthesis
  localparam longint CLK_KHZ = 200000;
  localparam longint AV_CLK_KHZ = 24576;
  localparam logic [31:0] NCO_INC = 32'((AV_CLK_KHZ << 32) / CLK_KHZ);
  // incoming bus beat; stamp is valid with sop
  typedef struct packed {
    logic sop;
    logic eop;
    logic crc_err;
    logic [15:0] stamp;
    logic [31:0] data;
  } iru_rx_beat_t;
  // outgoing av beat
  typedef struct packed {
    logic sop;
    logic eop;
    logic is_stamp;
    logic [2:0] bytes;
    logic [31:0] data;
  } iru_av_beat_t;
  // per-packet descriptor
  typedef struct packed {
    logic crc_err;
    logic [15:0] stamp;
    logic [15:0] syt;
    logic [MEM_AW:0] len;
  } iru_desc_t;
  typedef enum logic [1:0] {DL_IDLE, DL_STAMP, DL_DATA} iru_dl_state_t;
endpackage : iru_pkg

// ---- logic/iru_sync2.sv ----
`timescale 1ns/1ps
module iru_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // two flops per bit; first flop feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_reg[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_reg[i] <= d[i];
        q[i] <= meta_reg[i];
      end
    end
  end
endmodule : iru_sync2

// ---- logic/iru_clk_gen.sv ----
`timescale 1ns/1ps
module iru_clk_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // rate select
  input wire logic [1:0] sel,
  // clock out
  output logic clk_out,
  output logic clk_oe,
  output logic rise
);
  import iru_pkg::*;
  logic [31:0] acc_reg;
  logic [31:0] inc;
  // rate halves for each step of the select code
  assign inc = (sel == 2'h0) ? 32'h0 : (NCO_INC >> (sel - 2'h1));
  // phase accumulator, msb is the clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= 32'h0;
      clk_out <= 1'b0;
      clk_oe <= 1'b0;
      rise <= 1'b0;
    end else begin
      acc_reg <= acc_reg + inc;
      clk_out <= acc_reg[31];
      clk_oe <= (sel != 2'h0);
      rise <= acc_reg[31] & ~clk_out;
    end
  end
endmodule : iru_clk_gen

// ---- logic/iru_unpack_control.sv ----
`timescale 1ns/1ps
module iru_unpack_control (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus receive side
  input wire logic rx_valid,
  input wire iru_pkg::iru_rx_beat_t rx_beat,
  input wire logic [15:0] cycle_time,
  // av port clock pin
  input wire logic av_port_clock_pin_i,
  output logic av_port_clock_pin_o,
  output logic av_port_clock_pin_oe,
  // av port data
  input wire logic av_ready,
  output logic av_valid,
  output iru_pkg::iru_av_beat_t av_beat,
  output logic av_frame_sync,
  // interrupt
  output logic irq
);
  import iru_pkg::*;

  logic [31:0] ctrl_reg;
  logic [31:0] hq1_reg;
  logic [31:0] hq2_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_event;
  logic [1:0] rx_app_clock_select;
  logic send_at_once;
  logic stamp_check_off;
  logic drop_bad_packets;
  logic packet_ready_flag;
  logic rx_enable_bit;
  logic [1:0] byte_pad_trim;
  logic syt_process_enable;
  logic rx_soft_reset;

  // control fields
  assign rx_app_clock_select = ctrl_reg[CLK_SEL_LSB+:2];
  assign send_at_once = ctrl_reg[SEND_AT_ONCE_BIT];
  assign stamp_check_off = ctrl_reg[STAMP_OFF_BIT];
  assign drop_bad_packets = ctrl_reg[DROP_BIT];
  assign rx_enable_bit = ctrl_reg[ENABLE_BIT];
  assign byte_pad_trim = ctrl_reg[PAD_LSB+:2];
  assign syt_process_enable = ctrl_reg[SYT_EN_BIT];
  assign rx_soft_reset = ctrl_reg[SOFT_RST_BIT];

  // av clock: own generator or sampled pin
  logic gen_rise;
  logic pin_s;
  logic pin_prev_reg;
  logic ready_s;
  logic av_edge;
  logic srst_reg;
  // RULE_01 clock out drive
  // RULE_02 select decode
  iru_clk_gen u_clk_gen (
    .clk(pclk),
    .rst_n(presetn),
    .sel(rx_app_clock_select),
    .clk_out(av_port_clock_pin_o),
    .clk_oe(av_port_clock_pin_oe),
    .rise(gen_rise)
  );
  iru_sync2 #(.W(2)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({av_ready, av_port_clock_pin_i}),
    .q({ready_s, pin_s})
  );
  // edge detect on synchronised pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_s;
    end
  end
  assign av_edge = av_port_clock_pin_oe ? gen_rise : (pin_s & ~pin_prev_reg);

  // RULE_12 reset taken on an av clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= rx_soft_reset & (srst_reg | av_edge);
    end
  end

  // buffer memory and descriptors
  logic [31:0] mem [2**MEM_AW];
  iru_desc_t desc_mem [2**DESC_AW];
  logic [MEM_AW:0] wr_ptr_reg;
  logic [MEM_AW:0] wr_tmp_reg;
  logic [MEM_AW:0] rd_ptr_reg;
  logic [DESC_AW:0] desc_wr_reg;
  logic [DESC_AW:0] desc_rd_reg;
  logic accept_reg;
  logic ovf_pkt_reg;
  logic [1:0] qidx_reg;
  logic [15:0] stamp_in_reg;
  logic mem_full;
  logic desc_full;
  logic store_beat;
  logic end_pkt;
  logic commit;
  logic [MEM_AW:0] pkt_len;
  logic [MEM_AW:0] wr_tmp_next;

  assign mem_full = (wr_tmp_reg - rd_ptr_reg) == MEM_DEPTH;
  assign desc_full = (desc_wr_reg[DESC_AW] != desc_rd_reg[DESC_AW])
    && (desc_wr_reg[DESC_AW-1:0] == desc_rd_reg[DESC_AW-1:0]);
  assign store_beat = rx_valid && !rx_beat.sop && accept_reg && (qidx_reg == PAYLOAD_IDX)
    && !ovf_pkt_reg && !mem_full;
  assign wr_tmp_next = wr_tmp_reg + {{MEM_AW{1'b0}}, store_beat};
  assign pkt_len = wr_tmp_next - wr_ptr_reg;
  assign end_pkt = rx_valid && rx_beat.eop && !rx_beat.sop && accept_reg;
  assign commit = end_pkt && !ovf_pkt_reg && !(qidx_reg == PAYLOAD_IDX && mem_full)
    && (pkt_len != '0) && !desc_full;
  // RULE_08 stored packet present
  assign packet_ready_flag = desc_wr_reg != desc_rd_reg;

  // payload and descriptor storage
  always_ff @(posedge pclk) begin
    if (store_beat) begin
      mem[wr_tmp_reg[MEM_AW-1:0]] <= rx_beat.data;
    end
    // RULE_18 crc status kept with packet
    if (commit) begin
      desc_mem[desc_wr_reg[DESC_AW-1:0]] <= '{crc_err: rx_beat.crc_err,
        stamp: stamp_in_reg, syt: hq2_reg[15:0], len: pkt_len};
    end
  end

  // receive side capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accept_reg <= 1'b0;
      ovf_pkt_reg <= 1'b0;
      qidx_reg <= 2'h0;
      stamp_in_reg <= 16'h0;
      wr_tmp_reg <= '0;
      wr_ptr_reg <= '0;
      desc_wr_reg <= '0;
      hq1_reg <= 32'h0;
      hq2_reg <= HQ2_RESET;
    end else if (srst_reg) begin
      accept_reg <= 1'b0;
      ovf_pkt_reg <= 1'b0;
      qidx_reg <= 2'h0;
      wr_tmp_reg <= '0;
      wr_ptr_reg <= '0;
      desc_wr_reg <= '0;
      hq2_reg <= HQ2_RESET;
    end else if (rx_valid) begin
      if (rx_beat.sop) begin
        // RULE_09 enable sampled per packet
        accept_reg <= rx_enable_bit;
        qidx_reg <= 2'h1;
        ovf_pkt_reg <= 1'b0;
        wr_tmp_reg <= wr_ptr_reg;
        stamp_in_reg <= rx_beat.stamp;
        // RULE_14 last bus header
        if (rx_enable_bit) begin
          hq1_reg <= rx_beat.data;
        end
      end else if (accept_reg) begin
        if (qidx_reg != PAYLOAD_IDX) begin
          qidx_reg <= qidx_reg + 2'h1;
        end
        // RULE_15 RULE_16 RULE_17 second cip quadlet fields
        if (qidx_reg == 2'h2) begin
          hq2_reg <= rx_beat.data;
        end
        if (qidx_reg == PAYLOAD_IDX && mem_full) begin
          ovf_pkt_reg <= 1'b1;
        end
        wr_tmp_reg <= wr_tmp_next;
        if (rx_beat.eop) begin
          accept_reg <= 1'b0;
          wr_ptr_reg <= commit ? wr_tmp_next : wr_ptr_reg;
          desc_wr_reg <= desc_wr_reg + {{DESC_AW{1'b0}}, commit};
        end
      end
    end
  end

  // delivery decision for head packet
  iru_desc_t head;
  iru_dl_state_t state_reg;
  logic [15:0] stamp_gap;
  logic stamp_due;
  logic release_ok;
  logic drop_head;
  logic xfer;
  logic last_word;
  logic [MEM_AW:0] cnt_reg;
  logic [2:0] last_bytes;
  assign head = desc_mem[desc_rd_reg[DESC_AW-1:0]];
  assign stamp_gap = cycle_time - head.stamp;
  assign stamp_due = !stamp_gap[15];
  // RULE_03 crc packet sent at once
  // RULE_04 otherwise wait for stamp
  assign release_ok = (send_at_once && head.crc_err) || stamp_check_off || stamp_due;
  // RULE_07 bad packet discarded
  assign drop_head = drop_bad_packets && head.crc_err;
  assign xfer = av_valid && ready_s && av_edge;
  assign last_word = (cnt_reg + 7'h1) == head.len;
  // RULE_10 trim pad bytes from last quadlet
  assign last_bytes = FULL_BYTES - {1'b0, byte_pad_trim};

  // delivery state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= DL_IDLE;
      rd_ptr_reg <= '0;
      desc_rd_reg <= '0;
      cnt_reg <= '0;
      av_valid <= 1'b0;
      av_beat <= '0;
      av_frame_sync <= 1'b0;
    end else if (srst_reg) begin
      state_reg <= DL_IDLE;
      rd_ptr_reg <= '0;
      desc_rd_reg <= '0;
      cnt_reg <= '0;
      av_valid <= 1'b0;
      av_frame_sync <= 1'b0;
    end else begin
      av_frame_sync <= 1'b0;
      case (state_reg)
        DL_IDLE: begin
          if (packet_ready_flag && drop_head) begin
            rd_ptr_reg <= rd_ptr_reg + head.len;
            desc_rd_reg <= desc_rd_reg + 4'h1;
          end else if (packet_ready_flag && release_ok) begin
            av_valid <= 1'b1;
            cnt_reg <= '0;
            // RULE_11 syt marks frame start
            av_frame_sync <= syt_process_enable && (head.syt != SYT_NONE);
            // RULE_05 stamp quadlet leads
            if (stamp_check_off) begin
              state_reg <= DL_STAMP;
              av_beat <= '{sop: 1'b1, eop: 1'b0, is_stamp: 1'b1, bytes: FULL_BYTES,
                data: {16'h0, head.stamp}};
            end else begin
              state_reg <= DL_DATA;
              av_beat <= '{sop: 1'b1, eop: head.len == 7'h1, is_stamp: 1'b0,
                bytes: (head.len == 7'h1) ? last_bytes : FULL_BYTES,
                data: mem[rd_ptr_reg[MEM_AW-1:0]]};
            end
          end
        end
        DL_STAMP: begin
          if (xfer) begin
            state_reg <= DL_DATA;
            av_beat <= '{sop: 1'b0, eop: head.len == 7'h1, is_stamp: 1'b0,
              bytes: (head.len == 7'h1) ? last_bytes : FULL_BYTES,
              data: mem[rd_ptr_reg[MEM_AW-1:0]]};
          end
        end
        DL_DATA: begin
          if (xfer) begin
            rd_ptr_reg <= rd_ptr_reg + 7'h1;
            if (last_word) begin
              state_reg <= DL_IDLE;
              av_valid <= 1'b0;
              desc_rd_reg <= desc_rd_reg + 4'h1;
            end else begin
              cnt_reg <= cnt_reg + 7'h1;
              av_beat <= '{sop: 1'b0, eop: (cnt_reg + 7'h2) == head.len, is_stamp: 1'b0,
                bytes: ((cnt_reg + 7'h2) == head.len) ? last_bytes : FULL_BYTES,
                data: mem[6'(rd_ptr_reg[MEM_AW-1:0] + 6'h1)]};
            end
          end
        end
        default: begin
          state_reg <= DL_IDLE;
        end
      endcase
    end
  end

  // interrupt events
  assign irq_event[IRQ_STORED] = commit;
  assign irq_event[IRQ_LOST] = end_pkt && !commit;
  assign irq_event[IRQ_DROPPED] = (state_reg == DL_IDLE) && packet_ready_flag && drop_head
    && !srst_reg;
  assign irq_event[IRQ_DELIVERED] = (state_reg == DL_DATA) && xfer && last_word && !srst_reg;

  // apb decode helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction : hit

  logic wr_en;
  logic setup;
  logic [31:0] rd_value;
  logic mapped;
  assign wr_en = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign mapped = hit(paddr, CTRL_OFFSET) || hit(paddr, HQ1_OFFSET) || hit(paddr, HQ2_OFFSET)
    || hit(paddr, IRQ_STATUS_OFFSET) || hit(paddr, IRQ_MASK_OFFSET);
  assign pready = 1'b1;

  // read mux
  always_comb begin
    rd_value = 32'h0;
    if (hit(paddr, CTRL_OFFSET)) begin
      rd_value = ctrl_reg;
      rd_value[READY_BIT] = packet_ready_flag;
    end else if (hit(paddr, HQ1_OFFSET)) begin
      rd_value = hq1_reg;
    end else if (hit(paddr, HQ2_OFFSET)) begin
      rd_value = hq2_reg;
    end else if (hit(paddr, IRQ_STATUS_OFFSET)) begin
      rd_value = {28'h0, irq_status_reg};
    end else if (hit(paddr, IRQ_MASK_OFFSET)) begin
      rd_value = {28'h0, irq_mask_reg};
    end
  end

  // read data and error registered in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0 : rd_value;
      pslverr <= !mapped;
    end
  end

  // control and mask writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      if (hit(paddr, CTRL_OFFSET)) begin
        ctrl_reg <= pwdata & CTRL_WMASK;
      end
      if (hit(paddr, IRQ_MASK_OFFSET)) begin
        irq_mask_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // sticky status, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~((wr_en && hit(paddr, IRQ_STATUS_OFFSET))
        ? pwdata[IRQ_W-1:0] : '0)) | irq_event;
    end
  end

  // level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // checks
  clk_out_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    rx_app_clock_select != 2'h0 |=> av_port_clock_pin_oe) else $error("clock not driven");
  clk_in_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    rx_app_clock_select == 2'h0 |=> !av_port_clock_pin_oe) else $error("pin not input");
  crc_immediate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    state_reg == DL_IDLE && packet_ready_flag && head.crc_err && send_at_once && !drop_head
    && !srst_reg |=> av_valid) else $error("crc packet not released");
  stamp_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    state_reg == DL_IDLE && !send_at_once && !stamp_check_off && !stamp_due
    |=> !av_valid) else $error("released before stamp");
  stamp_first_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    $rose(av_valid) |-> av_beat.is_stamp == $past(stamp_check_off))
    else $error("stamp quadlet order wrong");
  drop_bad_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    state_reg == DL_IDLE && packet_ready_flag && drop_head && !srst_reg
    |=> !av_valid && desc_rd_reg == $past(desc_rd_reg) + 4'h1) else $error("bad not dropped");
  ready_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    setup && !pwrite && hit(paddr, CTRL_OFFSET) |=> prdata[READY_BIT] == $past(packet_ready_flag))
    else $error("ready flag wrong");
  enable_sample_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    rx_valid && rx_beat.sop && !srst_reg |=> accept_reg == $past(rx_enable_bit))
    else $error("enable not sampled");
  soft_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    srst_reg |=> state_reg == DL_IDLE && !av_valid && !packet_ready_flag)
    else $error("soft reset ineffective");
  pkt_delivered_c: cover property (@(posedge pclk) disable iff (!presetn)
    irq_event[IRQ_DELIVERED]);
  pkt_dropped_c: cover property (@(posedge pclk) disable iff (!presetn)
    irq_event[IRQ_DROPPED]);
  stamp_lead_c: cover property (@(posedge pclk) disable iff (!presetn)
    av_valid && av_beat.is_stamp && xfer);
endmodule : iru_unpack_control

// ---- testbench/iru_av_app.sv ----
`timescale 1ns/1ps
module iru_av_app (
  // bench clock
  input wire logic pclk,
  // av port
  input wire logic av_valid,
  input wire iru_pkg::iru_av_beat_t av_beat,
  output logic av_clk,
  output logic av_ready
);
  import iru_pkg::*;
  iru_av_beat_t got[$];
  iru_av_beat_t last_beat;
  logic last_valid = 1'b0;
  logic [7:0] lf = 8'h5a;
  initial av_clk = 1'b0;
  always #24 av_clk = ~av_clk;
  // random stalls, changed away from the rising edge
  initial av_ready = 1'b0;
  always @(negedge av_clk) begin
    lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    av_ready <= lf[1:0] != 2'b00;
  end
  // stamp quadlets are taken like data
  always @(posedge pclk) begin
    if (av_valid && (!last_valid || av_beat !== last_beat)) got.push_back(av_beat);
    last_valid <= av_valid;
    last_beat <= av_beat;
  end
endmodule : iru_av_app

// ---- testbench/test_iru_unpack_control.sv ----
`timescale 1ns/1ps
module test_iru_unpack_control;
  import iru_pkg::*;
  localparam logic [31:0] EN = 32'h1 << ENABLE_BIT;
  localparam logic [31:0] OFF = 32'h1 << STAMP_OFF_BIT;
  localparam logic [31:0] DROP = 32'h1 << DROP_BIT;
  localparam logic [31:0] SAO = 32'h1 << SEND_AT_ONCE_BIT;
  localparam logic [31:0] SYT = 32'h1 << SYT_EN_BIT;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic rx_valid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, r, b, h;
  logic pready, pslverr, e, pin_o, pin_oe, av_valid, fsync, irq, av_clk, av_ready;
  iru_rx_beat_t rx_beat = '0;
  iru_av_beat_t av_beat;
  logic [15:0] cycle_time = 16'h0;
  logic [31:0] lfsr = 32'h6c59;
  logic [1:0] pad;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int fs_cnt = 0;
  int n, f, c, pv;
  wire pin = pin_oe ? pin_o : av_clk;
  iru_unpack_control DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_valid, .rx_beat, .cycle_time,
    .av_port_clock_pin_i(pin), .av_port_clock_pin_o(pin_o), .av_port_clock_pin_oe(pin_oe),
    .av_ready, .av_valid, .av_beat, .av_frame_sync(fsync), .irq);
  iru_av_app app (.pclk, .av_valid, .av_beat, .av_clk, .av_ready);
  always #2.5 pclk = ~pclk;
  // bus time, sync pulse count and hang limit
  always @(posedge pclk) begin
    cycle_time <= cycle_time + 16'h1;
    fs_cnt <= fs_cnt + int'(fsync);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      end_sim();
    end
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %s exp %h got %h", s, x, g);
    end
  endtask : chk
  task automatic idle(input int k);
    repeat (k) @(posedge pclk);
  endtask : idle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // wait for the answer; only the bench timeout ends a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // header, cip1, cip2, then k payload words from base d
  task automatic send(input logic [31:0] d, input int k, input logic crc, input logic [15:0] st);
    for (int i = -3; i < k; i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_beat <= '{sop: i == -3, eop: i == k - 1, crc_err: crc, stamp: st,
        data: i == -3 ? d : i == -1 ? h : i < 0 ? 32'h0 : d + 32'(i)};
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
  endtask : send
  task automatic take(input int k, input logic st);
    iru_av_beat_t v;
    int t;
    t = 0;
    while (app.got.size() < k + int'(st) && t < 3000) begin
      @(posedge pclk);
      t++;
    end
    for (int i = -int'(st); i < k; i++) begin
      v = app.got.size() > 0 ? app.got.pop_front() : '0;
      if (i < 0) chk("stamp_first", 1, v.is_stamp);
      else chk("data", b + 32'(i), v.data);
      if (i == k - 1) chk("last_bytes", 32'(FULL_BYTES) - pad, v.bytes);
    end
  endtask : take
  task automatic pkt(input logic [31:0] cfg, input logic crc, input logic [15:0] dt);
    apb(1'b1, CTRL_OFFSET, cfg);
    b = rnd();
    send(b, 3, crc, cycle_time + dt);
  endtask : pkt
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFFSET, 0);
    chk("ctrl_reset", CTRL_RESET, q);
    apb(1'b0, HQ2_OFFSET, 0);
    chk("hq2_reset", HQ2_RESET, q);
    apb(1'b0, 12'hffc, 0);
    chk("unmapped", 1, e);
    apb(1'b1, IRQ_MASK_OFFSET, 32'h1 << IRQ_DELIVERED);
    $display("test reset done");
    for (int t = 0; t < 6; t++) begin
      r = rnd();
      pad = r[1:0];
      n = 1 + int'(r[4:2]);
      h = {2'b10, r[10:5], 8'h00, 16'(t)};
      apb(1'b1, CTRL_OFFSET, EN | SYT | {28'h0, pad, 2'b00});
      f = fs_cnt;
      b = rnd();
      send(b, n, 1'b0, cycle_time);
      take(n, 1'b0);
      apb(1'b0, HQ1_OFFSET, 0);
      chk("hq1", b, q);
      apb(1'b0, HQ2_OFFSET, 0);
      chk("hq2", h, q);
      chk("frame_sync", 32'(f + 1), 32'(fs_cnt));
    end
    pad = 2'b00;
    $display("test random done");
    pkt(EN | OFF, 1'b0, 16'h7000);
    take(3, 1'b1);
    pkt(EN, 1'b1, 16'h0800);
    idle(300);
    chk("held", 0, app.got.size());
    apb(1'b0, CTRL_OFFSET, 0);
    chk("ready_flag", 1, q[READY_BIT]);
    take(3, 1'b0);
    idle(3);
    chk("irq_on", 1, irq);
    apb(1'b1, IRQ_MASK_OFFSET, 0);
    idle(3);
    chk("irq_masked", 0, irq);
    apb(1'b1, IRQ_STATUS_OFFSET, 32'hf);
    apb(1'b0, IRQ_STATUS_OFFSET, 0);
    chk("irq_clear", 0, q[IRQ_DELIVERED]);
    $display("test stamp done");
    pkt(EN | SAO, 1'b1, 16'h7000);
    take(3, 1'b0);
    pkt(EN | DROP, 1'b1, 16'h0000);
    idle(300);
    chk("dropped", 0, app.got.size());
    apb(1'b0, IRQ_STATUS_OFFSET, 0);
    chk("drop_event", 1, q[IRQ_DROPPED]);
    r = b;
    pkt(32'h0, 1'b0, 16'h0000);
    idle(300);
    chk("disabled", 0, app.got.size());
    apb(1'b0, HQ1_OFFSET, 0);
    chk("hq1_kept", r, q);
    $display("test error done");
    pkt(EN, 1'b0, 16'h0800);
    idle(50);
    // receive off first, stored packet drains
    apb(1'b1, CTRL_OFFSET, 32'h0);
    take(3, 1'b0);
    do begin
      apb(1'b0, CTRL_OFFSET, 0);
    end while (q[READY_BIT] !== 1'b0);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    idle(30);
    apb(1'b1, CTRL_OFFSET, EN);
    apb(1'b0, CTRL_OFFSET, 0);
    chk("srst_flag", 0, q[READY_BIT]);
    apb(1'b0, HQ2_OFFSET, 0);
    chk("srst_hq2", HQ2_RESET, q);
    // pointers must be coherent again after the soft reset
    pkt(EN, 1'b0, 16'h0000);
    take(3, 1'b0);
    chk("srst_flush", 0, app.got.size());
    for (int s = 3; s >= 0; s--) begin
      apb(1'b1, CTRL_OFFSET, 32'(s) << CLK_SEL_LSB);
      idle(50);
      c = 0;
      repeat (2000) begin
        pv = int'(pin);
        @(posedge pclk);
        if (pin === 1'b1 && pv == 0) c++;
      end
      chk("clk_drive", s != 0, pin_oe);
      if (s > 0) begin
        // rising edges of 24.576 MHz over 10 us, halved per select step
        n = 246 >> (s - 1);
        chk("clk_rate", 1, c >= n - 2 && c <= n + 2);
      end
    end
    $display("test clock done");
    end_sim();
  end
endmodule : test_iru_unpack_control
